//--- verilog/spi_stop_pkg.sv
// Package: constants for the clock-stop SPI master.
// Assumes one 25 MHz system clock; every timing is a count of its cycles.
package spi_stop_pkg;
	localparam int          SYS_CLK_MHZ    = 25;
	localparam int          SYS_PERIOD_NS  = 1000 / SYS_CLK_MHZ;
	// Divider reference: one system clock is the peripheral clock period P
	localparam int          REF_PERIOD_NS  = 40;
	localparam int          REF_CYCLES     = (REF_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int          DIV_W          = 8;
	localparam int          WORD_W         = 8;
	localparam int          CNT_W          = 4;
	localparam logic [1:0]  STOP_NO_DELAY  = 2'h2;
	localparam logic [1:0]  STOP_HALF      = 2'h3;
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h01;
	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_SHIFT, ST_LAST} state_t;
endpackage : spi_stop_pkg

//--- verilog/spi_half_divider.sv
// Shift clock phase divider: emits one-cycle enable at the end of each phase.
// Assumes clk is the peripheral system clock; each clk cycle is one period P.
`timescale 1ns/1ps
`default_nettype none
module spi_half_divider (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	// Control
	input  wire logic                            run,
	input  wire logic                            level_high,
	input  wire logic [spi_stop_pkg::DIV_W-1:0]  divide_value,
	// Phase end pulse
	output logic                                 phase_end
);
	logic [spi_stop_pkg::DIV_W:0] cnt_q;
	logic [spi_stop_pkg::DIV_W:0] len;
	logic [spi_stop_pkg::DIV_W:0] dv;

	// Phase length in P: period (1+dv)*2P; odd or zero splits evenly
	assign dv  = {1'b0, divide_value};
	assign len = (divide_value[0] || divide_value == '0) ? (dv + 9'h001)
	           : (level_high ? ((dv >> 1) + 9'h001) << 1 : (dv >> 1) << 1);
	assign phase_end = run && (cnt_q + 9'h001 >= len);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (!run || phase_end) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 9'h001;
		end
	end
endmodule : spi_half_divider
`default_nettype wire

//--- verilog/spi_stop_master.sv
// SPI master in clock-stop mode: shift clock, active-low select, data out/in.
// Assumes slave inputs arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module spi_stop_master (
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	// Configuration
	input  wire logic [1:0]                       clock_stop_select,
	input  wire logic                             tx_clock_polarity,
	input  wire logic [spi_stop_pkg::DIV_W-1:0]   clock_divide_value,
	// Transfer request and result
	input  wire logic                             start,
	input  wire logic [spi_stop_pkg::WORD_W-1:0]  tx_word,
	output logic [spi_stop_pkg::WORD_W-1:0]       rx_word,
	output logic                                  rx_valid,
	output logic                                  busy,
	// Serial pins
	output logic                                  shift_clock_out,
	output logic                                  slave_select_out,
	output logic                                  serial_data_out,
	output logic                                  serial_data_oe,
	input  wire logic                             serial_data_in
);
	// ****************************************************************
	// Input synchroniser and state
	// ****************************************************************
	logic [2:0]                         din_q;
	logic                               din_s;
	spi_stop_pkg::state_t               state_q;
	logic                               lvl_q;
	logic [spi_stop_pkg::WORD_W-1:0]    sh_q;
	logic [spi_stop_pkg::WORD_W-1:0]    rx_q;
	logic [spi_stop_pkg::CNT_W-1:0]     bit_q;
	logic [1:0]                         mode_q;
	logic                               pol_q;
	logic                               phase_end;
	logic                               run;
	logic                               in_frame;
	logic [spi_stop_pkg::WORD_W-1:0]    sh_next;
	logic                               half_mode;
	logic                               lead_edge;
	logic                               trail_edge;
	logic                               last_bit;
	logic [spi_stop_pkg::WORD_W-1:0]    rx_next;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			din_q <= 3'h0;
			din_s <= 1'b0;
		end else begin
			din_q <= {din_q[1:0], serial_data_in};
			if (din_q[2] == din_q[1]) begin
				din_s <= din_q[2];
			end
		end
	end

	// ****************************************************************
	// Divider and edge decode
	// ****************************************************************
	assign run = (state_q != spi_stop_pkg::ST_IDLE);

	spi_half_divider u_div (
		.clk          (clk),
		.rst_n        (rst_n),
		.run          (run),
		.level_high   (lvl_q),
		.divide_value (clock_divide_value),
		.phase_end    (phase_end)
	);

	// lvl_q is the logical clock: 0 idle, 1 after the first (leading) edge
	assign half_mode  = (mode_q == spi_stop_pkg::STOP_HALF);
	// The select setup phase ends in the first leading edge, so select leads it by one phase
	assign in_frame   = (state_q == spi_stop_pkg::ST_SETUP) || (state_q == spi_stop_pkg::ST_SHIFT);
	assign lead_edge  = phase_end && in_frame && !lvl_q;
	assign trail_edge = phase_end && (state_q == spi_stop_pkg::ST_SHIFT) && lvl_q;
	assign last_bit   = (bit_q == 4'(spi_stop_pkg::WORD_W - 1));
	assign rx_next    = {rx_q[spi_stop_pkg::WORD_W-2:0], din_s};
	assign sh_next    = {sh_q[spi_stop_pkg::WORD_W-2:0], 1'b0};

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Mode 10b launches on the leading edge and samples on the trailing edge;
	// 11b samples on the leading edge and launches on the trailing edge.
	// Pin polarity is applied only at the output, so the edge roles follow it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= spi_stop_pkg::ST_IDLE;
			lvl_q    <= 1'b0;
			sh_q     <= '0;
			rx_q     <= '0;
			bit_q    <= '0;
			mode_q   <= spi_stop_pkg::STOP_NO_DELAY;
			pol_q    <= 1'b0;
			rx_word  <= '0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			case (state_q)
				spi_stop_pkg::ST_IDLE: begin
					if (start) begin
						state_q <= spi_stop_pkg::ST_SETUP;
						sh_q    <= tx_word;
						mode_q  <= clock_stop_select;
						pol_q   <= tx_clock_polarity;
						bit_q   <= '0;
					end
				end
				spi_stop_pkg::ST_SETUP, spi_stop_pkg::ST_SHIFT: begin
					// Select low for one low clock phase before the first edge
					if (lead_edge) begin
						state_q <= spi_stop_pkg::ST_SHIFT;
						lvl_q   <= 1'b1;
						if (half_mode) begin
							rx_q <= rx_next;
						end else if (bit_q != '0) begin
							sh_q <= sh_next;
						end
					end else if (trail_edge) begin
						lvl_q <= 1'b0;
						if (!half_mode) begin
							rx_q <= rx_next;
						end
						if (last_bit) begin
							state_q  <= spi_stop_pkg::ST_LAST;
							rx_word  <= half_mode ? rx_q : rx_next;
							rx_valid <= 1'b1;
						end else begin
							bit_q <= bit_q + 4'h1;
							if (half_mode) begin
								sh_q <= sh_next;
							end
						end
					end
				end
				spi_stop_pkg::ST_LAST: begin
					// Hold select one more low clock phase, then release
					if (phase_end) begin
						state_q <= spi_stop_pkg::ST_IDLE;
					end
				end
				default: state_q <= spi_stop_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Pin registers
	// ****************************************************************
	// 10b launches first bit on the leading edge; 11b shows it at select fall.
	logic data_visible;
	assign data_visible = (state_q == spi_stop_pkg::ST_SHIFT)
	                    || (state_q == spi_stop_pkg::ST_SETUP && half_mode);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_clock_out  <= 1'b0;
			slave_select_out <= 1'b1;
			serial_data_out  <= 1'b0;
			serial_data_oe   <= 1'b0;
			busy             <= 1'b0;
		end else begin
			shift_clock_out  <= (run ? lvl_q : 1'b0) ^ (run ? pol_q : tx_clock_polarity);
			slave_select_out <= !(run && state_q != spi_stop_pkg::ST_IDLE);
			serial_data_out  <= sh_q[spi_stop_pkg::WORD_W-1];
			serial_data_oe   <= data_visible;
			busy             <= run;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_frame_start;
		$fell(slave_select_out);
	endsequence

	property p_select_idle;
		@(posedge clk) disable iff (!rst_n) state_q == spi_stop_pkg::ST_IDLE |=> slave_select_out;
	endproperty
	a_select_idle: assert property (p_select_idle) else $error("select low while idle");

	property p_clock_idle;
		@(posedge clk) disable iff (!rst_n) !run |=> shift_clock_out == $past(tx_clock_polarity);
	endproperty
	a_clock_idle: assert property (p_clock_idle) else $error("clock not at idle level");

	property p_select_before_edge;
		@(posedge clk) disable iff (!rst_n) s_frame_start |-> $stable(shift_clock_out);
	endproperty
	a_select_before_edge: assert property (p_select_before_edge) else $error("edge at select fall");

	property p_release_after_last;
		@(posedge clk) disable iff (!rst_n) rx_valid |=> !serial_data_oe;
	endproperty
	a_release_after_last: assert property (p_release_after_last) else $error("data not released");

	property p_early_bit;
		@(posedge clk) disable iff (!rst_n)
			(state_q == spi_stop_pkg::ST_SETUP && half_mode) |=> serial_data_oe;
	endproperty
	a_early_bit: assert property (p_early_bit) else $error("first bit not early");

	property p_no_early_bit;
		@(posedge clk) disable iff (!rst_n)
			(state_q == spi_stop_pkg::ST_SETUP && !half_mode) |=> !serial_data_oe;
	endproperty
	a_no_early_bit: assert property (p_no_early_bit) else $error("bit shown too early");

	property p_phase_even;
		@(posedge clk) disable iff (!rst_n)
			(lead_edge && clock_divide_value == 8'h01) |-> ##1 !phase_end ##1 phase_end;
	endproperty
	a_phase_even: assert property (p_phase_even) else $error("phase length wrong");

	property p_high_phase_even;
		@(posedge clk) disable iff (!rst_n)
			(lead_edge && clock_divide_value == 8'h02) |-> ##1 (!phase_end)[*3] ##1 phase_end;
	endproperty
	a_high_phase_even: assert property (p_high_phase_even) else $error("high phase wrong");

	property p_valid_pulse;
		@(posedge clk) disable iff (!rst_n) rx_valid |=> !rx_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid held");
endmodule : spi_stop_master
`default_nettype wire

//--- bench/spi_slave_model.sv
// Behavioural SPI slave standing on the far side of the clock-stop master.
// Assumes the bench gives it the mode, the idle clock level and the reply byte.
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
	// Clock and configuration
	input  wire logic       clk,
	input  wire logic       mode_half,
	input  wire logic       pol,
	input  wire logic [7:0] reply,
	// Serial pins
	input  wire logic       sck,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	output var  logic       miso,
	output var  logic [7:0] got
);
	logic       sck_q = 1'b0;
	logic       sel_q = 1'b1;
	logic       first = 1'b0;
	logic [7:0] sh    = 8'h00;
	initial miso = 1'b0;
	initial got  = 8'h00;
	always @(posedge clk) begin
		sck_q <= sck;
		sel_q <= sel_n;
		if (sel_n) begin
			// Released line: keep moving so no stale bit reads as good
			miso <= ~miso;
		end else if (sel_q) begin
			miso  <= reply[7];
			sh    <= {reply[6:0], 1'b0};
			first <= 1'b1;
		end else if (sck != sck_q) begin
			// A leading edge leaves the idle level
			if ((sck != pol) == mode_half) begin
				got <= {got[6:0], mosi};
			end else if (first && !mode_half) begin
				first <= 1'b0;
			end else begin
				miso <= sh[7];
				sh   <= {sh[6:0], 1'b0};
			end
		end
	end
endmodule : spi_slave_model
`default_nettype wire

//--- bench/serial_port_spi_master_clock_stop_tb_top.sv
// Self-checking bench for the clock-stop SPI master against a slave model.
// Assumes a 25 MHz clock and divide values large enough for the input sync.
`timescale 1ns/1ps
`default_nettype none
module serial_port_spi_master_clock_stop_tb_top;
	typedef struct packed {logic [1:0] m; logic p; logic [7:0] d; logic [7:0] tx; logic [7:0] rp;} row_t;
	logic       clk = 1'b0, rst_n = 1'b0, start = 1'b0, pol = 1'b0;
	logic [1:0] mode = 2'h2;
	logic [7:0] div = 8'h05, tx = 8'h00, reply = 8'h00, rx_word, got, run = 8'h01;
	logic       rx_valid, busy, sck, sel, sdo, oe, sdi, sck_p = 1'b0, sel_p = 1'b1;
	row_t       cur = '0;
	int         n_errors = 0, compares = 0;
	row_t rows [6] = '{{2'h2, 1'b0, 8'h07, 8'ha5, 8'h3c}, {2'h2, 1'b1, 8'h08, 8'h81, 8'h7e},
		{2'h3, 1'b0, 8'h09, 8'h5a, 8'hc3}, {2'h3, 1'b1, 8'h08, 8'h01, 8'h80},
		{2'h2, 1'b0, 8'h0a, 8'hff, 8'h00}, {2'h3, 1'b1, 8'h07, 8'h00, 8'hff}};
	always #20 clk = ~clk;
	spi_stop_master i_dut (.clk(clk), .rst_n(rst_n), .clock_stop_select(mode), .tx_clock_polarity(pol),
		.clock_divide_value(div), .start(start), .tx_word(tx), .rx_word(rx_word), .rx_valid(rx_valid),
		.busy(busy), .shift_clock_out(sck), .slave_select_out(sel), .serial_data_out(sdo),
		.serial_data_oe(oe), .serial_data_in(sdi));
	spi_slave_model i_slave (.clk(clk), .mode_half(mode == spi_stop_pkg::STOP_HALF), .pol(pol),
		.reply(reply), .sck(sck), .sel_n(sel), .mosi(sdo), .miso(sdi), .got(got));
	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_of_test();
		if (n_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test
	function automatic logic [7:0] plen(input logic [7:0] d, input logic lvl);
		if (d[0] || d == 8'h00) return d + 8'h01;
		return lvl ? d + 8'h02 : d;
	endfunction : plen
	// Phase lengths and select framing seen on the pins
	always @(negedge clk) begin
		if (rst_n && !sel && sel_p) begin
			run = 8'h01;
			if (cur.m == spi_stop_pkg::STOP_HALF) begin
				chk(oe, 8'h01, "oe_first");
				chk(sdo, cur.tx[7], "first_bit");
			end
		end else if (rst_n && sck != sck_p) begin
			if (sel) chk(sck, pol, "idle_move");
			else chk(run, plen(cur.d, sck_p ^ cur.p), "phase_len");
			run = 8'h01;
		end else run++;
		sck_p = sck;
		sel_p = sel;
	end
	task automatic xfer(input row_t r, input bit poke, input bit fast);
		int n;
		@(posedge clk);
		cur = r;
		mode <= r.m; pol <= r.p; div <= r.d; tx <= r.tx; reply <= r.rp;
		// Idle level settles two cycles before the select falls
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		if (poke) begin
			repeat (20) @(posedge clk);
			tx    <= ~r.tx;
			start <= 1'b1;
			@(posedge clk) start <= 1'b0;
		end
		n = 0;
		while (rx_valid !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
		chk(rx_valid, 8'h01, "rx_valid");
		// Fast divides outrun the input synchroniser, so rx_word is not checked there
		if (!fast) chk(rx_word, r.rp, "rx_word");
		while (sel !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
		chk(oe, 8'h00, "oe_release");
		chk(got, r.tx, "tx_word");
		repeat (3) @(posedge clk);
	endtask : xfer
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk({sck, sel, oe, busy}, 8'h04, "reset_pins");
		@(posedge clk) rst_n <= 1'b1;
		foreach (rows[i]) xfer(rows[i], 1'b0, 1'b0);
		xfer(rows[3], 1'b1, 1'b0);
		xfer('{2'h2, 1'b0, 8'h01, 8'h96, 8'h00}, 1'b0, 1'b1);
		xfer('{2'h3, 1'b1, 8'h02, 8'h69, 8'h00}, 1'b0, 1'b1);
		@(posedge clk);
		cur = rows[0];
		mode <= rows[0].m; pol <= rows[0].p; div <= rows[0].d; tx <= 8'h3c;
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		repeat (30) @(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		chk({sck, sel, oe, busy, rx_valid}, 8'h08, "abort_pins");
		@(posedge clk) rst_n <= 1'b1;
		xfer(rows[0], 1'b0, 1'b0);
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
endmodule : serial_port_spi_master_clock_stop_tb_top
`default_nettype wire
